// file: include/erxf_defs.vh
// Register offsets, field positions and reset values for the receive filter block
`ifndef ERXF_DEFS_VH
`define ERXF_DEFS_VH

// Register byte offsets
`define ERXF_OFS_MASK_SET   8'h00
`define ERXF_OFS_MASK_CLR   8'h04
`define ERXF_OFS_STAT_RAW   8'h08
`define ERXF_OFS_STAT_MSK   8'h0c
`define ERXF_OFS_IRQ_STAT   8'h10
`define ERXF_OFS_RX_CTRL    8'h14

// Interrupt enable / pending bit positions
`define ERXF_STATS_BIT      0
`define ERXF_HOST_BIT       1

// Receive frame handling control fields
`define ERXF_KEEP_FCS       30
`define ERXF_QOS_EN         29
`define ERXF_SINGLE_BUF     28
`define ERXF_COPY_CTRL      24
`define ERXF_COPY_SHORT     23
`define ERXF_COPY_ERR       22
`define ERXF_COPY_UNM       21
`define ERXF_PROM_CH_HI     18
`define ERXF_PROM_CH_LO     16
`define ERXF_BCAST_EN       13
`define ERXF_BCAST_CH_HI    10
`define ERXF_BCAST_CH_LO    8
`define ERXF_MCAST_EN       5
`define ERXF_MCAST_CH_HI    2
`define ERXF_MCAST_CH_LO    0
`define ERXF_RX_CTRL_WMASK  32'h71e72727

// Reset values
`define ERXF_RST_EN         2'h0
`define ERXF_RST_RX_CTRL    32'h00000000

// Frame check sequence length in bytes
`define ERXF_FCS_BYTES      16'h0004

`endif

// file: src/erxf_rx_filter.v
// Receive frame filter controls, MAC interrupt enables and per-frame delivery decision
//
// Operation
// - Writing one to mask-clear bit 1 disables the host-error interrupt.
// - Writing one to mask-clear bit 0 disables the statistics interrupt.
// - Zeros written to mask-clear change nothing; reads return current enables.
// - All fields reset to zero: enables off, copy and pass options off.
// - Bit 30 clear strips FCS from length; set keeps FCS and counts it.
// - Bit 29 enables receive quality of service handling.
// - Bit 28 clear lets a frame span several consecutive buffers.
// - Bit 28 set puts each frame in one buffer, dropping overflow bytes.
// - Single-buffer mode reports full frame byte count, up to 65535.
// - Bit 24 set copies control frames to memory; clear filters them.
// - Pause frames act when pause handling enabled, regardless of copy bit.
// - Control frames copied by bit 24 carry control flag in last descriptor.
// - Bit 23 copies frames under 64 bytes with frag_flag/short_frame_flag flag.
// - Bit 22 copies errored frames with error flag; clear filters them.
// - Bit 21 sends unmatched frames to promiscuous channel, marked unmatched.
// - Bits 18-16 select promiscuous channel 0 to 7 in binary.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "erxf_defs.vh"

module erxf_rx_filter #(
	parameter ADDR_W = 8,
	parameter LEN_W  = 16
) (
	// Clock and reset
	input  wire              clk,
	input  wire              rst,
	// Register port
	input  wire [ADDR_W-1:0] reg_addr,
	input  wire [31:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [31:0]       reg_rdata,
	// Raw interrupt sources and pause handling enable from the MAC core
	input  wire              host_error_pending,
	input  wire              stats_pending,
	input  wire              pause_handling_en,
	// Interrupt
	output reg               irq,
	// Frame end report from the receive parser
	input  wire              fd_valid,
	input  wire              fd_is_ctrl,
	input  wire              fd_is_pause,
	input  wire              fd_short,
	input  wire              fd_error,
	input  wire              fd_addr_match,
	input  wire [2:0]        fd_match_ch,
	input  wire              fd_bcast,
	input  wire              fd_mcast_hit,
	input  wire [LEN_W-1:0]  fd_len,
	input  wire [LEN_W-1:0]  fd_buf_len,
	// Delivery decision toward the receive DMA
	output reg               fo_valid,
	output reg               fo_deliver,
	output reg  [2:0]        fo_channel,
	output reg  [LEN_W-1:0]  fo_pkt_len,
	output reg  [LEN_W-1:0]  fo_store_len,
	output reg               fo_ctrl_flag,
	output reg               fo_frag_flag,
	output reg               fo_short_flag,
	output reg               fo_err_flag,
	output reg               fo_unmatched_flag,
	output reg               fo_pause_act,
	// Static controls toward the DMA
	output reg               rx_qos_enable,
	output reg               single_buffer_frames,
	output reg               keep_fcs_enable
);

	reg  [1:0]       irq_en_r;
	reg  [1:0]       irq_en_nxt;
	reg  [1:0]       pend_d_r;
	reg  [1:0]       irq_stat_r;
	reg  [1:0]       irq_stat_nxt;
	reg  [31:0]      rx_ctrl_r;
	reg  [31:0]      rdata_nxt;
	wire [1:0]       pend;
	wire [1:0]       pend_rise;
	wire             hit_set;
	wire             hit_clr;
	wire             hit_ist;
	wire             hit_ctl;
	wire             wr_set;
	wire             wr_clr;
	wire             wr_ist;
	wire             wr_ctl;

	// Controls decoded from the frame handling register
	wire             copy_ctrl_frames_enable;
	wire             copy_short_frames_enable;
	wire             copy_errored_frames_enable;
	wire             copy_unmatched_frames_enable;
	wire [2:0]       promiscuous_channel_sel;
	wire             bcast_rx_enable;
	wire [2:0]       bcast_channel_sel;
	wire             mcast_rx_enable;
	wire [2:0]       mcast_channel_sel;

	// Frame decision terms
	reg              addr_ok;
	reg  [2:0]       chan;
	reg              pass;
	reg  [LEN_W-1:0] plen;
	reg  [LEN_W-1:0] slen;

	// Next values of the registered report and interrupt
	reg              deliver_nxt;
	reg              ctrl_flag_nxt;
	reg              frag_flag_nxt;
	reg              short_flag_nxt;
	reg              err_flag_nxt;
	reg              unm_flag_nxt;
	reg              pause_act_nxt;
	reg              irq_nxt;

	function wr_hit;
		input [ADDR_W-1:0] a;
		input [7:0]        ofs;
		begin
			wr_hit = (a == ofs[ADDR_W-1:0]);
		end
	endfunction

	// Descriptor length; stripping the FCS saturates so a runt never wraps
	function [LEN_W-1:0] desc_len;
		input [LEN_W-1:0] len;
		input             keep;
		begin
			if (keep)
				desc_len = len;
			else if (len > `ERXF_FCS_BYTES)
				desc_len = len - `ERXF_FCS_BYTES;
			else
				desc_len = {LEN_W{1'b0}};
		end
	endfunction

	// Bytes actually written; single-buffer mode cuts at the first buffer
	function [LEN_W-1:0] store_len;
		input [LEN_W-1:0] len;
		input [LEN_W-1:0] buf_len;
		input             one_buf;
		begin
			if (one_buf && len > buf_len)
				store_len = buf_len;
			else
				store_len = len;
		end
	endfunction

	assign hit_set = wr_hit(reg_addr, `ERXF_OFS_MASK_SET);
	assign hit_clr = wr_hit(reg_addr, `ERXF_OFS_MASK_CLR);
	assign hit_ist = wr_hit(reg_addr, `ERXF_OFS_IRQ_STAT);
	assign hit_ctl = wr_hit(reg_addr, `ERXF_OFS_RX_CTRL);

	assign wr_set = reg_wr & hit_set;
	assign wr_clr = reg_wr & hit_clr;
	assign wr_ist = reg_wr & hit_ist;
	assign wr_ctl = reg_wr & hit_ctl;

	assign pend = {host_error_pending, stats_pending};
	assign pend_rise = pend & ~pend_d_r;

	assign copy_ctrl_frames_enable      = rx_ctrl_r[`ERXF_COPY_CTRL];
	assign copy_short_frames_enable     = rx_ctrl_r[`ERXF_COPY_SHORT];
	assign copy_errored_frames_enable   = rx_ctrl_r[`ERXF_COPY_ERR];
	assign copy_unmatched_frames_enable = rx_ctrl_r[`ERXF_COPY_UNM];
	assign promiscuous_channel_sel      = rx_ctrl_r[`ERXF_PROM_CH_HI:`ERXF_PROM_CH_LO];
	assign bcast_rx_enable              = rx_ctrl_r[`ERXF_BCAST_EN];
	assign bcast_channel_sel            = rx_ctrl_r[`ERXF_BCAST_CH_HI:`ERXF_BCAST_CH_LO];
	assign mcast_rx_enable              = rx_ctrl_r[`ERXF_MCAST_EN];
	assign mcast_channel_sel            = rx_ctrl_r[`ERXF_MCAST_CH_HI:`ERXF_MCAST_CH_LO];

	// Interrupt enables: set side and clear side share one flop pair
	always @* begin
		irq_en_nxt = irq_en_r;
		if (wr_set)
			irq_en_nxt = irq_en_r | reg_wdata[1:0];
		if (wr_clr) begin
			irq_en_nxt[`ERXF_HOST_BIT]  = irq_en_r[`ERXF_HOST_BIT] & ~reg_wdata[`ERXF_HOST_BIT];
			irq_en_nxt[`ERXF_STATS_BIT] = irq_en_r[`ERXF_STATS_BIT] & ~reg_wdata[`ERXF_STATS_BIT];
		end
	end

	// Sticky event bits; a new event beats a simultaneous clear
	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (wr_ist)
			irq_stat_nxt = irq_stat_r & ~reg_wdata[1:0];
		irq_stat_nxt = irq_stat_nxt | pend_rise;
	end

	// Read mux; unmapped offsets and reserved bits read zero
	always @* begin
		rdata_nxt = 32'h00000000;
		case (reg_addr)
			`ERXF_OFS_MASK_SET: rdata_nxt[1:0] = irq_en_r;
			`ERXF_OFS_MASK_CLR: rdata_nxt[1:0] = irq_en_r;
			`ERXF_OFS_STAT_RAW: rdata_nxt[1:0] = pend;
			`ERXF_OFS_STAT_MSK: rdata_nxt[1:0] = pend & irq_en_r;
			`ERXF_OFS_IRQ_STAT: rdata_nxt[1:0] = irq_stat_r;
			`ERXF_OFS_RX_CTRL:  rdata_nxt = rx_ctrl_r;
			default:            rdata_nxt = 32'h00000000;
		endcase
	end

	// Frame delivery decision
	always @* begin
		addr_ok = 1'b1;
		chan    = fd_match_ch;
		if (fd_addr_match)
			chan = fd_match_ch;
		else if (fd_bcast && bcast_rx_enable)
			chan = bcast_channel_sel;
		else if (fd_mcast_hit && mcast_rx_enable)
			chan = mcast_channel_sel;
		else begin
			addr_ok = 1'b0;
			chan    = promiscuous_channel_sel;
		end
		pass = (addr_ok || copy_unmatched_frames_enable)
			&& (!fd_is_ctrl || copy_ctrl_frames_enable)
			&& (!fd_short || copy_short_frames_enable)
			&& (!fd_error || copy_errored_frames_enable);
		plen = desc_len(fd_len, keep_fcs_enable);
		slen = store_len(plen, fd_buf_len, single_buffer_frames);
	end

	// Descriptor flags only ever accompany a delivered frame
	always @* begin
		deliver_nxt    = fd_valid & pass;
		ctrl_flag_nxt  = deliver_nxt & fd_is_ctrl;
		frag_flag_nxt  = deliver_nxt & fd_short & fd_error;
		short_flag_nxt = deliver_nxt & fd_short & ~fd_error;
		err_flag_nxt   = deliver_nxt & fd_error;
		unm_flag_nxt   = deliver_nxt & ~addr_ok;
		pause_act_nxt  = fd_valid & fd_is_pause & pause_handling_en;
		irq_nxt        = |(irq_stat_r & irq_en_r);
	end

	// Register file, read port and interrupt
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_en_r   <= `ERXF_RST_EN;
			rx_ctrl_r  <= `ERXF_RST_RX_CTRL;
			pend_d_r   <= 2'h0;
			irq_stat_r <= 2'h0;
			irq        <= 1'b0;
			reg_rdata  <= 32'h00000000;
		end else begin
			irq_en_r   <= irq_en_nxt;
			pend_d_r   <= pend;
			irq_stat_r <= irq_stat_nxt;
			irq        <= irq_nxt;
			reg_rdata  <= reg_rd ? rdata_nxt : 32'h00000000;
			if (wr_ctl)
				rx_ctrl_r <= reg_wdata & `ERXF_RX_CTRL_WMASK;
		end
	end

	// Mirrored as flops so the DMA sees stable levels
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_qos_enable        <= 1'b0;
			single_buffer_frames <= 1'b0;
			keep_fcs_enable      <= 1'b0;
		end else begin
			rx_qos_enable        <= rx_ctrl_r[`ERXF_QOS_EN];
			single_buffer_frames <= rx_ctrl_r[`ERXF_SINGLE_BUF];
			keep_fcs_enable      <= rx_ctrl_r[`ERXF_KEEP_FCS];
		end
	end

	// One report per frame end; controls changed mid-frame are not guarded
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fo_valid          <= 1'b0;
			fo_deliver        <= 1'b0;
			fo_channel        <= 3'h0;
			fo_pkt_len        <= {LEN_W{1'b0}};
			fo_store_len      <= {LEN_W{1'b0}};
			fo_ctrl_flag      <= 1'b0;
			fo_frag_flag      <= 1'b0;
			fo_short_flag     <= 1'b0;
			fo_err_flag       <= 1'b0;
			fo_unmatched_flag <= 1'b0;
			fo_pause_act      <= 1'b0;
		end else begin
			fo_valid          <= fd_valid;
			fo_deliver        <= deliver_nxt;
			fo_channel        <= chan;
			fo_pkt_len        <= plen;
			fo_store_len      <= slen;
			fo_ctrl_flag      <= ctrl_flag_nxt;
			fo_frag_flag      <= frag_flag_nxt;
			fo_short_flag     <= short_flag_nxt;
			fo_err_flag       <= err_flag_nxt;
			fo_unmatched_flag <= unm_flag_nxt;
			fo_pause_act      <= pause_act_nxt;
		end
	end

endmodule // erxf_rx_filter

// file: testbench/erxf_properties.sv
// Checker on the register port and frame report ports
`timescale 1ns/10ps
module erxf_properties (
	// Watched ports
	input wire        clk, rst, reg_wr, reg_rd, fd_valid, fd_is_pause, pause_handling_en,
	input wire        fo_valid, fo_deliver, fo_pause_act, rx_qos_enable, keep_fcs_enable,
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata, reg_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence clr_rd(b);
		reg_wr && reg_addr == 8'h04 && reg_wdata[b] ##1 reg_rd && reg_addr == 8'h04;
	endsequence
	sequence ctl_wr;
		reg_wr && reg_addr == 8'h14 ##1 !(reg_wr && reg_addr == 8'h14);
	endsequence
	a_host_clear: assert property (clr_rd(1) |=> !reg_rdata[1])
		else $error("host enable survived clear");
	a_stats_clear: assert property (clr_rd(0) |=> !reg_rdata[0])
		else $error("stats enable survived clear");
	a_rsvd_ctrl: assert property (reg_rd && reg_addr == 8'h14 |=> (reg_rdata & 32'h8e18d8d8) == 32'h0)
		else $error("reserved control bits set");
	a_rsvd_mask: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:2] == 30'h0)
		else $error("reserved enable bits set");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_report_lag: assert property (fo_valid == $past(fd_valid))
		else $error("report not one cycle after frame");
	a_pause_act: assert property (fd_valid && fd_is_pause && pause_handling_en |=> fo_pause_act)
		else $error("pause frame not acted on");
	a_qos_mirror: assert property (ctl_wr |=> rx_qos_enable == $past(reg_wdata[29], 2))
		else $error("qos enable does not follow control");
	a_fcs_mirror: assert property (ctl_wr |=> keep_fcs_enable == $past(reg_wdata[30], 2))
		else $error("fcs keep does not follow control");
	a_deliver_valid: assert property (fo_deliver |-> fo_valid)
		else $error("deliver without report");
endmodule // erxf_properties

// file: testbench/erxf_dma_model.sv
// Receive DMA side: totals bytes written for delivered frames
`timescale 1ns/10ps
module erxf_dma_model (
	// Decision from the filter
	input  wire        clk,
	input  wire        fo_valid,
	input  wire        fo_deliver,
	input  wire [15:0] fo_store_len,
	// Running byte total
	output reg  [31:0] stored_total
);
	initial stored_total = 32'h0;
	// Filtered frames never reach memory
	always @(posedge clk) begin
		if (fo_valid && fo_deliver) begin
			stored_total <= stored_total + fo_store_len;
		end
	end
endmodule // erxf_dma_model

// file: testbench/tb_emac_rx_filter_and_irq_mask.sv
// Self-checking bench: registers, interrupt and frame decisions
`timescale 1ns/10ps
module tb_emac_rx_filter_and_irq_mask;
	reg         clk, rst, reg_wr, reg_rd, host_error_pending, stats_pending, pause_handling_en;
	reg         fd_valid, fd_is_ctrl, fd_is_pause, fd_short, fd_error, fd_addr_match, fd_bcast, fd_mcast_hit;
	reg  [7:0]  reg_addr;
	reg  [31:0] reg_wdata, ctrl, total;
	reg  [2:0]  fd_match_ch;
	reg  [15:0] fd_len, fd_buf_len, pk, st;
	reg  [4:0]  d;
	wire [31:0] reg_rdata, stored_total;
	wire [15:0] fo_pkt_len, fo_store_len;
	wire [2:0]  fo_channel;
	wire        irq, fo_valid, fo_deliver, fo_ctrl_flag, fo_unmatched_flag, fo_pause_act;
	wire        fo_frag_flag, fo_short_flag, fo_err_flag;
	wire        rx_qos_enable, single_buffer_frames, keep_fcs_enable;
	integer     seed, bad_count, comparisons, i;
	erxf_rx_filter i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.host_error_pending, .stats_pending, .pause_handling_en, .irq, .fd_valid, .fd_is_ctrl,
		.fd_is_pause, .fd_short, .fd_error, .fd_addr_match, .fd_match_ch, .fd_bcast, .fd_mcast_hit,
		.fd_len, .fd_buf_len, .fo_valid, .fo_deliver, .fo_channel, .fo_pkt_len, .fo_store_len,
		.fo_ctrl_flag, .fo_frag_flag, .fo_short_flag, .fo_err_flag, .fo_unmatched_flag,
		.fo_pause_act, .rx_qos_enable, .single_buffer_frames, .keep_fcs_enable);
	erxf_dma_model i_dma (.clk, .fo_valid, .fo_deliver, .fo_store_len, .stored_total);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		begin
			{reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
			@(posedge clk);
			reg_wr <= 1'b0;
			#1;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			{reg_addr, reg_rd} <= {a, 1'b1};
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, e);
		end
	endtask
	task end_sim;
		begin
			if (bad_count == 0 && comparisons > 0) $display("bench passed");
			else $display("bench failed");
			$finish;
		end
	endtask
	// Address acceptance, delivery and channel, in that bit order
	function [4:0] dec(input [31:0] c);
		reg a;
		begin
			a = fd_addr_match | (fd_bcast & c[13]) | (fd_mcast_hit & c[5]);
			dec[4] = a;
			dec[3] = (a | c[21]) & (!fd_is_ctrl | c[24]) & (!fd_short | c[23]) & (!fd_error | c[22]);
			dec[2:0] = fd_addr_match ? fd_match_ch : (fd_bcast & c[13]) ? c[10:8] :
				(fd_mcast_hit & c[5]) ? c[2:0] : c[18:16];
		end
	endfunction
	initial begin
		{rst, reg_wr, reg_rd, host_error_pending, stats_pending, pause_handling_en} = 6'h20;
		{fd_valid, fd_is_ctrl, fd_is_pause, fd_short, fd_error, fd_addr_match, fd_bcast, fd_mcast_hit} = 8'h0;
		{reg_addr, reg_wdata, fd_match_ch, fd_len, fd_buf_len} = 0;
		{seed, bad_count, comparisons, total} = {32'd99, 32'd0, 32'd0, 32'd0};
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(8'h14, 32'h0);
		rd(8'h04, 32'h0);
		wr(8'h00, 32'hffffffff);
		rd(8'h04, 32'h3);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'h3);
		wr(8'h04, 32'h2);
		rd(8'h04, 32'h1);
		wr(8'h04, 32'h1);
		rd(8'h04, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h20, 32'h0);
		wr(8'h00, 32'h3);
		host_error_pending <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(irq, 1);
		wr(8'h04, 32'h2);
		repeat (2) @(posedge clk);
		#1 chk(irq, 0);
		stats_pending <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(irq, 1);
		wr(8'h04, 32'h1);
		wr(8'h10, 32'h3);
		repeat (2) @(posedge clk);
		#1 chk(irq, 0);
		stats_pending <= 1'b0;
		@(posedge clk);
		#1 stats_pending <= 1'b1;
		wr(8'h10, 32'h1);
		rd(8'h10, 32'h1);
		rd(8'h0c, 32'h0);
		for (i = 0; i < 80; i = i + 1) begin
			ctrl = $random(seed);
			wr(8'h14, ctrl);
			rd(8'h14, ctrl & 32'h71e72727);
			@(posedge clk);
			{fd_is_ctrl, fd_is_pause, fd_short, fd_error, fd_addr_match, fd_bcast} <= $random(seed);
			{fd_mcast_hit, pause_handling_en, fd_match_ch, fd_valid} <= {$random(seed), 1'b1};
			fd_len <= (i < 6) ? i : (i == 6) ? 16'hffff : $random(seed);
			fd_buf_len <= $random(seed);
			@(posedge clk);
			fd_valid <= 1'b0;
			#1 d = dec(ctrl);
			pk = ctrl[30] ? fd_len : (fd_len <= 16'h4 ? 16'h0 : fd_len - 16'h4);
			st = (ctrl[28] && fd_buf_len < pk) ? fd_buf_len : pk;
			chk(fo_deliver, d[3]);
			chk(fo_pause_act, fd_is_pause & pause_handling_en);
			chk(fo_valid, 1);
			chk(fo_frag_flag, d[3] & fd_short & fd_error);
			chk(fo_short_flag, d[3] & fd_short & !fd_error);
			chk(fo_err_flag, d[3] & fd_error);
			chk({rx_qos_enable, single_buffer_frames, keep_fcs_enable}, {ctrl[29], ctrl[28], ctrl[30]});
			if (d[3]) begin
				chk(fo_channel, d[2:0]);
				chk(fo_unmatched_flag, !d[4]);
				chk(fo_ctrl_flag, fd_is_ctrl);
				chk(fo_pkt_len, pk);
				chk(fo_store_len, st);
				total = total + st;
			end
		end
		@(posedge clk);
		#1 chk(stored_total, total);
		end_sim;
	end
endmodule // tb_emac_rx_filter_and_irq_mask
bind erxf_rx_filter erxf_properties u_chk (.clk, .rst, .reg_wr, .reg_rd, .fd_valid, .fd_is_pause,
	.pause_handling_en, .fo_valid, .fo_deliver, .fo_pause_act, .rx_qos_enable, .keep_fcs_enable,
	.reg_addr, .reg_wdata, .reg_rdata);
